// ### core/core_clocking_pkg.sv
package core_clocking_pkg;

  // primary clock figures
  localparam int unsigned CORE_CLK_PERIOD_NS   = 50;
  localparam int unsigned CORE_CLK_MULTIPLIER  = 1;
  // debug clock limit kept by the probe: 40 MHz, 25 ns period
  localparam int unsigned DEBUG_CLK_MIN_PER_NS = 25;

  // bus ratio figures
  localparam int unsigned BUS_RATIO_MIN        = 1;
  localparam int unsigned BUS_RATIO_MAX        = 4;
  localparam logic [2:0]  RATIO_ONE            = 3'h1;
  localparam logic [2:0]  RATIO_TOP            = 3'h4;

  localparam int unsigned BUS_ADDR_W           = 32;
  localparam int unsigned BUS_DATA_W           = 32;
  localparam logic [1:0]  HTRANS_IDLE          = 2'h0;

  // debug shift path
  localparam int unsigned DEBUG_SHIFT_W        = 8;
  localparam logic [7:0]  DEBUG_WAKE_CODE      = 8'hA5;
  localparam logic [7:0]  DEBUG_SHIFT_RESET    = 8'h00;

  typedef enum logic [1:0] {
    ST_RUN   = 2'b00,
    ST_DRAIN = 2'b01,
    ST_SLEEP = 2'b10
  } power_state_t;

  typedef struct packed {
    logic [BUS_DATA_W-1:0] hrdata;
    logic                  hready;
    logic                  hresp;
  } bus_in_t;

  typedef struct packed {
    logic [BUS_ADDR_W-1:0] haddr;
    logic [1:0]            htrans;
    logic                  hwrite;
    logic [BUS_DATA_W-1:0] hwdata;
  } bus_out_t;

  localparam bus_in_t  BUS_IN_RESET  = '{hrdata: 32'h0000_0000,
                                         hready: 1'b1, hresp: 1'b0};
  localparam bus_out_t BUS_OUT_RESET = '{haddr: 32'h0000_0000,
                                         htrans: 2'h0, hwrite: 1'b0,
                                         hwdata: 32'h0000_0000};

endpackage : core_clocking_pkg

// ### core/clock_gate_cell.sv
`timescale 1ns/1ps
// glitch-free gate: enable is held while the clock is high
module clock_gate_cell
(
  input  wire logic clk_in,
  input  wire logic gate_en,
  output      logic clk_out
);

  logic en_hold;

  // level-sensitive hold, not an edge-triggered flop
  always_latch
  begin
    if (!clk_in)
      en_hold = gate_en;
  end

  assign clk_out = clk_in & en_hold;

endmodule : clock_gate_cell

// ### core/debug_clock_domain.sv
`timescale 1ns/1ps
module debug_clock_domain
  import core_clocking_pkg::*;
(
  input  wire logic debug_test_clock,
  input  wire logic debug_rst_n,
  input  wire logic debug_data_in,
  input  wire logic debug_capture,
  output      logic debug_data_out,
  output      logic debug_wake_toggle
);

  logic [DEBUG_SHIFT_W-1:0] shift;

  // sample on the rising edge; nothing here ever touches clk_sys
  always_ff @(posedge debug_test_clock or negedge debug_rst_n)
  begin
    if (!debug_rst_n)
      shift <= DEBUG_SHIFT_RESET;
    else
      shift <= {debug_data_in, shift[DEBUG_SHIFT_W-1:1]};
  end

  // toggle, not pulse: the other domain may run far slower or stop
  always_ff @(posedge debug_test_clock or negedge debug_rst_n)
  begin
    if (!debug_rst_n)
      debug_wake_toggle <= 1'b0;
    else if (debug_capture && shift == DEBUG_WAKE_CODE)
      debug_wake_toggle <= ~debug_wake_toggle;
  end

  // launch on the falling edge, half a period before the probe samples
  always_ff @(negedge debug_test_clock or negedge debug_rst_n)
  begin
    if (!debug_rst_n)
      debug_data_out <= 1'b0;
    else
      debug_data_out <= shift[0];
  end

endmodule : debug_clock_domain

// ### core/core_clocking_and_bus_strobe.sv
`timescale 1ns/1ps
// How it works
// - Both clocks are used at their own rate with no multiply, divide or PLL.
// - Every primary-clock flop triggers on the rising edge only.
// - The logic is fully static, so the primary clock may stop and restart.
// - The debug clock domain is asynchronous and crosses only via synchronisers.
// - Debug-domain flops use both edges of the debug test clock.
// - A reference copy of the primary clock is tapped from the clock tree.
// - There is no reference clock output for the debug domain.
// - The bus and user-instruction reference clocks are gated off in sleep.
// - The bus runs synchronous to the primary clock at 1:1 to 4:1.
// - There is no bus clock input; bus flops use the primary clock and an enable.
// - The bus strobe is registered before it enables the bus flops.
// - With the enable high, bus inputs are captured.
// - With the enable high, bus data outputs are updated.
// - The bus reference clock shows the effective bus clock.
// - The sleep indicator is raised on entering sleep.
module core_clocking_and_bus_strobe
  import core_clocking_pkg::*;
(
  input  wire logic         clk_sys,
  input  wire logic         sys_rst,
  input  wire logic         bus_clock_strobe,
  input  wire bus_in_t      bus_in,
  input  wire bus_out_t     core_out,
  input  wire logic         sleep_req,
  input  wire logic         wake_event,
  input  wire logic         debug_test_clock,
  input  wire logic         debug_rst_n,
  input  wire logic         debug_data_in,
  input  wire logic         debug_capture,
  output      logic         debug_data_out,
  output      bus_in_t      bus_in_q,
  output      bus_out_t     bus_out,
  output      logic         bus_en,
  output      logic [2:0]   bus_ratio,
  output      logic         sleep_ind,
  output      logic         debug_wake,
  output      logic         core_clock_ref_out,
  output      logic         bus_clock_ref_out,
  output      logic         user_instr_clock_out
);

  power_state_t state;
  power_state_t next_state;
  logic         bus_gate_en;
  logic         udi_gate_en;
  logic [2:0]   gap_count;
  logic         dbg_toggle;
  logic         dbg_sync1;
  logic         dbg_sync2;
  logic         dbg_sync3;
  logic         dbg_pulse;
  logic         bus_idle;

  // saturating step of the strobe gap counter
  function automatic logic [2:0] sat_step(input logic [2:0] value);
    if (value >= RATIO_TOP)
      sat_step = RATIO_TOP;
    else
      sat_step = value + RATIO_ONE;
  endfunction : sat_step

  // strobe comes from same-clock system logic: one register, no more
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      bus_en <= 1'b0;
    else
      bus_en <= bus_clock_strobe;
  end

  // bus flops run on clk_sys, qualified by the registered strobe
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      bus_in_q <= BUS_IN_RESET;
    else if (bus_en)
      bus_in_q <= bus_in;
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      bus_out <= BUS_OUT_RESET;
    else if (bus_en)
      bus_out <= core_out;
  end

  // measured ratio: cycles between registered strobes, 1..4
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      gap_count <= RATIO_ONE;
      bus_ratio <= RATIO_ONE;
    end
    else if (bus_en)
    begin
      gap_count <= RATIO_ONE;
      bus_ratio <= gap_count;
    end
    else
      gap_count <= sat_step(gap_count);
  end

  // debug toggle crosses on two flops; third flop only for the edge
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      dbg_sync1 <= 1'b0;
      dbg_sync2 <= 1'b0;
      dbg_sync3 <= 1'b0;
    end
    else
    begin
      dbg_sync1 <= dbg_toggle;
      dbg_sync2 <= dbg_sync1;
      dbg_sync3 <= dbg_sync2;
    end
  end

  assign dbg_pulse = dbg_sync2 ^ dbg_sync3;

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      debug_wake <= 1'b0;
    else
      debug_wake <= dbg_pulse;
  end

  // sleep only once the bus sits idle on a bus beat
  assign bus_idle = bus_en && (core_out.htrans == HTRANS_IDLE)
                    && bus_in.hready;

  always_comb
  begin
    next_state = state;
    case (state)
      ST_RUN:
        if (sleep_req)
          next_state = ST_DRAIN;
      ST_DRAIN:
        if (wake_event || dbg_pulse)
          next_state = ST_RUN;
        else if (bus_idle)
          next_state = ST_SLEEP;
      ST_SLEEP:
        if (wake_event || dbg_pulse)
          next_state = ST_RUN;
      default:
        next_state = ST_RUN;
    endcase
  end

  // no edge is counted on, so a stopped clk_sys just freezes the state
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      state <= ST_RUN;
    else
      state <= next_state;
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      sleep_ind <= 1'b0;
    else
      sleep_ind <= (next_state == ST_SLEEP);
  end

  // bus gate enable lines up with bus_en so the gated edge is the capture edge
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      bus_gate_en <= 1'b0;
      udi_gate_en <= 1'b0;
    end
    else
    begin
      bus_gate_en <= bus_clock_strobe && (next_state != ST_SLEEP);
      udi_gate_en <= (next_state != ST_SLEEP);
    end
  end

  // an always-on cell keeps the reference tap delay matched to the gated ones
  clock_gate_cell u_core_ref
  (
    .clk_in  (clk_sys),
    .gate_en (1'b1),
    .clk_out (core_clock_ref_out)
  );

  clock_gate_cell u_bus_ref
  (
    .clk_in  (clk_sys),
    .gate_en (bus_gate_en),
    .clk_out (bus_clock_ref_out)
  );

  clock_gate_cell u_udi_ref
  (
    .clk_in  (clk_sys),
    .gate_en (udi_gate_en),
    .clk_out (user_instr_clock_out)
  );

  // debug domain has no reference output of its own
  debug_clock_domain u_debug
  (
    .debug_test_clock  (debug_test_clock),
    .debug_rst_n       (debug_rst_n),
    .debug_data_in     (debug_data_in),
    .debug_capture     (debug_capture),
    .debug_data_out    (debug_data_out),
    .debug_wake_toggle (dbg_toggle)
  );

  property p_strobe_reg;
    @(posedge clk_sys) disable iff (sys_rst)
    bus_clock_strobe |=> bus_en;
  endproperty
  a_strobe_reg: assert property (p_strobe_reg)
    else $error("registered strobe missed");

  property p_no_strobe;
    @(posedge clk_sys) disable iff (sys_rst)
    !bus_clock_strobe |=> !bus_en;
  endproperty
  a_no_strobe: assert property (p_no_strobe)
    else $error("bus enable without strobe");

  property p_capture;
    @(posedge clk_sys) disable iff (sys_rst)
    bus_clock_strobe ##1 bus_en |=> bus_in_q == $past(bus_in);
  endproperty
  a_capture: assert property (p_capture)
    else $error("bus input not captured");

  property p_hold_in;
    @(posedge clk_sys) disable iff (sys_rst)
    !bus_en |=> $stable(bus_in_q) && $stable(bus_out);
  endproperty
  a_hold_in: assert property (p_hold_in)
    else $error("bus flop moved without enable");

  property p_drive;
    @(posedge clk_sys) disable iff (sys_rst)
    bus_en |=> bus_out == $past(core_out);
  endproperty
  a_drive: assert property (p_drive)
    else $error("bus output not updated");

  property p_sleep_gate;
    @(posedge clk_sys) disable iff (sys_rst)
    sleep_ind |-> !bus_gate_en && !udi_gate_en;
  endproperty
  a_sleep_gate: assert property (p_sleep_gate)
    else $error("reference clock enabled in sleep");

  property p_sleep_entry;
    @(posedge clk_sys) disable iff (sys_rst)
    $rose(sleep_ind) |-> $past(state == ST_DRAIN && bus_en);
  endproperty
  a_sleep_entry: assert property (p_sleep_entry)
    else $error("sleep entered off a bus beat");

  property p_sleep_ind;
    @(posedge clk_sys) disable iff (sys_rst)
    sleep_ind == (state == ST_SLEEP);
  endproperty
  a_sleep_ind: assert property (p_sleep_ind)
    else $error("sleep indicator disagrees with state");

  property p_hclk_follow;
    @(posedge clk_sys) disable iff (sys_rst)
    !sleep_ind && !$past(sleep_ind) |-> bus_gate_en == bus_en;
  endproperty
  a_hclk_follow: assert property (p_hclk_follow)
    else $error("bus reference clock off the bus beat");

  property p_ratio_2;
    @(posedge clk_sys) disable iff (sys_rst)
    bus_en ##1 !bus_en ##1 bus_en |=> bus_ratio == 3'h2;
  endproperty
  a_ratio_2: assert property (p_ratio_2)
    else $error("2:1 ratio not measured");

  property p_ratio_1;
    @(posedge clk_sys) disable iff (sys_rst)
    bus_en [*2] |=> bus_ratio == RATIO_ONE;
  endproperty
  a_ratio_1: assert property (p_ratio_1)
    else $error("1:1 ratio not measured");

endmodule : core_clocking_and_bus_strobe

// ### dv/bus_sys_model.sv
`timescale 1ns/1ps
module bus_sys_model
  import core_clocking_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       sys_rst,
  input  wire logic [2:0] ratio,
  input  wire logic       stall,
  input  wire logic       idle,
  output      logic       bus_clock_strobe,
  output      bus_in_t    bus_in
);
  integer     seed = 28490;
  logic [2:0] phase = 3'h0;
  logic       rst_s, stall_s, idle_s;
  logic [2:0] ratio_s;

  initial
  begin
    bus_clock_strobe = 1'b0;
    bus_in           = BUS_IN_RESET;
  end

  // one strobe cycle in every ratio cycles, steady high at 1:1
  always @(posedge clk_sys)
  begin
    // controls taken on the edge: the bench moves them 1 ns later
    rst_s   = sys_rst;
    stall_s = stall;
    idle_s  = idle;
    ratio_s = ratio;
    #1;
    if (rst_s || stall_s)
    begin
      bus_clock_strobe = 1'b0;
      phase            = 3'h0;
    end
    else
    begin
      bus_clock_strobe = (phase == 3'h0);
      phase            = (phase + 3'h1 >= ratio_s) ? 3'h0 : phase + 3'h1;
    end
    bus_in.hrdata = $random(seed);
    bus_in.hready = idle_s ? 1'b1 : 1'($random(seed));
    bus_in.hresp  = idle_s ? 1'b0 : 1'($random(seed));
  end
endmodule : bus_sys_model

// ### dv/core_clocking_and_bus_strobe_tb.sv
`timescale 1ns/1ps
module core_clocking_and_bus_strobe_tb
  import core_clocking_pkg::*;
();
  // no x-to-0 event at time zero, so no stray negedge compare
  logic       clk_sys = 1'b0;
  logic       sys_rst, bus_clock_strobe, sleep_req, wake_event;
  logic       debug_data_out, idle_d;
  logic [7:0] dshift;
  logic       debug_test_clock, debug_rst_n, debug_data_in, debug_capture;
  logic       bus_en, sleep_ind, debug_wake, stall, idle, chk, clk_hold;
  logic       core_ref, bus_ref, udi_ref, st_d, beat, have_prev, have_last;
  logic [2:0] ratio, bus_ratio, g;
  bus_in_t    bus_in, bus_in_q, last_in;
  bus_out_t   core_out, bus_out, last_out;
  bus_in_t    q_in[$];
  bus_out_t   q_out[$];
  logic [2:0] q_gap[$];
  integer     seed = 28490;
  int         err_total, n_checks, gap, n_wake, n;

  core_clocking_and_bus_strobe u_dut (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .bus_clock_strobe(bus_clock_strobe), .bus_in(bus_in),
    .core_out(core_out), .sleep_req(sleep_req), .wake_event(wake_event),
    .debug_test_clock(debug_test_clock), .debug_rst_n(debug_rst_n),
    .debug_data_in(debug_data_in), .debug_capture(debug_capture),
    .debug_data_out(debug_data_out), .bus_in_q(bus_in_q), .bus_out(bus_out),
    .bus_en(bus_en), .bus_ratio(bus_ratio), .sleep_ind(sleep_ind),
    .debug_wake(debug_wake), .core_clock_ref_out(core_ref),
    .bus_clock_ref_out(bus_ref), .user_instr_clock_out(udi_ref));

  bus_sys_model u_sys (.clk_sys(clk_sys), .sys_rst(sys_rst), .ratio(ratio),
    .stall(stall), .idle(idle), .bus_clock_strobe(bus_clock_strobe),
    .bus_in(bus_in));

  task automatic bad(input string m);
    err_total++;
    $display("MISMATCH %0t %s", $time, m);
  endtask : bad

  task automatic cmp_bit(input logic got, input logic exp, input string m);
    n_checks++;
    if (got !== exp)
      bad(m);
  endtask : cmp_bit

  task automatic cmp_beat(input bus_in_t gi, input bus_out_t go,
                          input bus_in_t ei, input bus_out_t eo);
    n_checks++;
    if (gi !== ei || go !== eo)
      bad("beat data");
  endtask : cmp_beat

  task automatic cmp_ratio(input logic [2:0] got, input logic [2:0] exp);
    n_checks++;
    if (got !== exp)
      bad("bus ratio");
  endtask : cmp_ratio

  task automatic step(input int k);
    repeat (k) @(posedge clk_sys);
    #1;
  endtask : step

  // sample mid high phase, where a gated clock would show
  task automatic look(input logic c, input logic b, input logic u);
    step(1);
    #11;
    cmp_bit(core_ref, c, "core ref clock");
    cmp_bit(bus_ref, b, "bus ref clock");
    cmp_bit(udi_ref, u, "udi ref clock");
  endtask : look

  task give_verdict;
    if (err_total == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : give_verdict

  initial
  begin
    clk_sys = 1'b0;
    forever
    begin
      #25;
      if (!clk_hold)
        clk_sys = ~clk_sys;
    end
  end

  always @(posedge clk_sys)
  begin
    idle_d = idle;
    #1;
    core_out.haddr  = $random(seed);
    core_out.htrans = idle_d ? HTRANS_IDLE : 2'($random(seed));
    core_out.hwrite = 1'($random(seed));
    core_out.hwdata = $random(seed);
  end

  // notes the expected capture of each beat from the strobe seen
  always @(posedge clk_sys)
  begin
    beat = 1'b0;
    if (debug_wake === 1'b1)
      n_wake++;
    if (sys_rst)
    begin
      st_d      = 1'b0;
      have_prev = 1'b0;
      have_last = 1'b1;
      last_in   = BUS_IN_RESET;
      last_out  = BUS_OUT_RESET;
    end
    else
    begin
      if (!chk)
      begin
        have_prev = 1'b0;
        have_last = 1'b0;
      end
      if (st_d)
      begin
        if (chk)
        begin
          q_in.push_back(bus_in);
          q_out.push_back(core_out);
          q_gap.push_back(have_prev ? 3'(gap > 4 ? 4 : gap) : 3'h0);
          beat = 1'b1;
        end
        have_prev = chk;
        gap       = 1;
      end
      else
        gap++;
      st_d = bus_clock_strobe;
    end
  end

  always @(negedge clk_sys)
  begin
    if (sys_rst)
      cmp_ratio(bus_ratio, RATIO_ONE);
    else
      cmp_bit(bus_en, st_d, "strobe enable");
    if (beat && q_in.size() > 0)
    begin
      last_in   = q_in.pop_front();
      last_out  = q_out.pop_front();
      g         = q_gap.pop_front();
      have_last = 1'b1;
      if (g != 3'h0)
        cmp_ratio(bus_ratio, g);
    end
    if (chk && have_last)
      cmp_beat(bus_in_q, bus_out, last_in, last_out);
  end

  task automatic sleep_wait;
    sleep_req = 1'b1;
    for (n = 0; n < 30 && sleep_ind !== 1'b1; n++)
      step(1);
    cmp_bit(sleep_ind, 1'b1, "sleep entry");
    sleep_req = 1'b0;
  endtask : sleep_wait

  initial
  begin
    {sys_rst, debug_capture, clk_hold, chk} = 4'h9;
    {sleep_req, wake_event, stall, idle} = 4'h0;
    {debug_test_clock, debug_rst_n, debug_data_in} = 3'h0;
    core_out = BUS_OUT_RESET;
    ratio    = RATIO_ONE;
    step(3);
    sys_rst     = 1'b0;
    debug_rst_n = 1'b1;
    // gate enables leave reset low, so the first high phase is gated
    look(1'b1, 1'b0, 1'b0);
    repeat (2)
      look(1'b1, st_d, 1'b1);
    for (int r = 1; r <= 4; r++)
    begin
      ratio = 3'(r);
      step(30);
    end
    stall = 1'b1;
    step(8);
    stall = 1'b0;
    // clock parked low, then restarted
    @(negedge clk_sys);
    clk_hold = 1'b1;
    #710;
    clk_hold = 1'b0;
    step(20);
    {chk, idle} = 2'h1;
    sleep_wait();
    step(1);
    repeat (4)
      look(1'b1, 1'b0, 1'b0);
    wake_event = 1'b1;
    step(1);
    cmp_bit(sleep_ind, 1'b0, "wake exit");
    wake_event = 1'b0;
    look(1'b1, st_d, 1'b1);
    sleep_wait();
    n_wake = 0;
    dshift = DEBUG_SHIFT_RESET;
    // probe clock at 25 MHz, parked low outside the frame
    // code goes in low bit first; one more edge then captures it
    for (int i = 8; i >= 0; i--)
    begin
      debug_data_in = (i == 0) ? 1'b0 : DEBUG_WAKE_CODE[8 - i];
      debug_capture = (i == 0);
      dshift        = {debug_data_in, dshift[7:1]};
      #10 debug_test_clock = 1'b1;
      #20 debug_test_clock = 1'b0;
      #10;
      cmp_bit(debug_data_out, dshift[0], "debug serial out");
    end
    step(10);
    cmp_bit(n_wake == 1, 1'b1, "debug wake pulse");
    cmp_bit(sleep_ind, 1'b0, "debug wake exit");
    {chk, idle} = 2'h2;
    step(20);
    give_verdict();
  end

  initial
  begin
    #100000;
    err_total++;
    give_verdict();
  end
endmodule : core_clocking_and_bus_strobe_tb
